// [design/edp_top.sv]
`timescale 1ns/1ns
module edp_top (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic probe_clock_line,
  input wire logic reset_pin_n,
  input wire logic mode_data_line_in,
  output logic mode_data_line_out,
  output logic mode_data_line_oe_n,
  input wire logic tdi_in,
  output logic tdo_out,
  output logic tdo_oe_n,
  input wire logic trace_serial_output,
  input wire logic trace_en,
  input wire logic swd_out,
  input wire logic swd_drive,
  input wire logic dp_tdo,
  input wire logic bsr_tdo,
  input wire logic system_manager_access_port_release,
  input wire logic access_port_select,
  output logic debugger_attached,
  output logic pins_forced,
  output logic tdi_tdo_released,
  output logic core_reset_req,
  output logic scan_mode,
  output logic tap_reset,
  output logic [3:0] ir_bscan,
  output logic [3:0] ir_dp,
  output edp_pkg::edp_dec_type dec,
  output logic sel_system_bus_ap,
  output logic sel_system_manager_ap,
  output logic tck_rise,
  output logic tck_fall,
  output logic shift_tdi
);
  // input synchronisers, two flops each
  logic [1:0] tck_s_q;
  logic [1:0] rst_s_q;
  logic [1:0] tms_s_q;
  logic [1:0] tdi_s_q;
  logic tck_q;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      tck_s_q <= 2'h0;
      rst_s_q <= 2'h0;
      tms_s_q <= 2'h0;
      tdi_s_q <= 2'h0;
      tck_q <= 1'b0;
    end else begin
      tck_s_q <= {tck_s_q[0], probe_clock_line};
      rst_s_q <= {rst_s_q[0], reset_pin_n};
      tms_s_q <= {tms_s_q[0], mode_data_line_in};
      tdi_s_q <= {tdi_s_q[0], tdi_in};
      tck_q <= tck_s_q[1];
    end
  end

  logic tck_r;
  logic tck_f;
  logic pin_rst_n;
  logic tms;
  assign tck_r = tck_s_q[1] & ~tck_q;
  assign tck_f = ~tck_s_q[1] & tck_q;
  assign pin_rst_n = rst_s_q[1];
  assign tms = tms_s_q[1];
  assign tck_rise = tck_r;
  assign tck_fall = tck_f;

  // attach detection; the core is left running
  logic attached_q;
  always_ff @(posedge mclk) begin
    if (!rst_n || !pin_rst_n) begin
      attached_q <= 1'b0;
    end else if (tck_f) begin
      attached_q <= 1'b1;
    end
  end
  assign debugger_attached = attached_q;
  assign pins_forced = attached_q;

  // core reset request: clock low while reset pin released
  logic pin_rst_q;
  logic req_q;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pin_rst_q <= 1'b0;
      req_q <= 1'b0;
    end else begin
      pin_rst_q <= pin_rst_n;
      if (system_manager_access_port_release) begin
        req_q <= 1'b0;
      end else if (pin_rst_n && !pin_rst_q && !tck_s_q[1]) begin
        req_q <= 1'b1;
      end
    end
  end
  assign core_reset_req = req_q;

  // tap state machine, stepped on probe clock rising edges
  edp_pkg::edp_tap_type tap_q;
  edp_pkg::edp_tap_type tap_d;
  always_comb begin
    tap_d = tap_q;
    unique case (tap_q)
      edp_pkg::EDP_TLR: tap_d = tms ? edp_pkg::EDP_TLR : edp_pkg::EDP_RTI;
      edp_pkg::EDP_RTI: tap_d = tms ? edp_pkg::EDP_SEL_DR : edp_pkg::EDP_RTI;
      edp_pkg::EDP_SEL_DR:
        tap_d = tms ? edp_pkg::EDP_SEL_IR : edp_pkg::EDP_CAP_DR;
      edp_pkg::EDP_CAP_DR:
        tap_d = tms ? edp_pkg::EDP_EX1_DR : edp_pkg::EDP_SH_DR;
      edp_pkg::EDP_SH_DR:
        tap_d = tms ? edp_pkg::EDP_EX1_DR : edp_pkg::EDP_SH_DR;
      edp_pkg::EDP_EX1_DR:
        tap_d = tms ? edp_pkg::EDP_UPD_DR : edp_pkg::EDP_PA_DR;
      edp_pkg::EDP_PA_DR:
        tap_d = tms ? edp_pkg::EDP_EX2_DR : edp_pkg::EDP_PA_DR;
      edp_pkg::EDP_EX2_DR:
        tap_d = tms ? edp_pkg::EDP_UPD_DR : edp_pkg::EDP_SH_DR;
      edp_pkg::EDP_UPD_DR:
        tap_d = tms ? edp_pkg::EDP_SEL_DR : edp_pkg::EDP_RTI;
      edp_pkg::EDP_SEL_IR:
        tap_d = tms ? edp_pkg::EDP_TLR : edp_pkg::EDP_CAP_IR;
      edp_pkg::EDP_CAP_IR:
        tap_d = tms ? edp_pkg::EDP_EX1_IR : edp_pkg::EDP_SH_IR;
      edp_pkg::EDP_SH_IR:
        tap_d = tms ? edp_pkg::EDP_EX1_IR : edp_pkg::EDP_SH_IR;
      edp_pkg::EDP_EX1_IR:
        tap_d = tms ? edp_pkg::EDP_UPD_IR : edp_pkg::EDP_PA_IR;
      edp_pkg::EDP_PA_IR:
        tap_d = tms ? edp_pkg::EDP_EX2_IR : edp_pkg::EDP_PA_IR;
      edp_pkg::EDP_EX2_IR:
        tap_d = tms ? edp_pkg::EDP_UPD_IR : edp_pkg::EDP_SH_IR;
      edp_pkg::EDP_UPD_IR:
        tap_d = tms ? edp_pkg::EDP_SEL_DR : edp_pkg::EDP_RTI;
    endcase
  end

  logic scan_q;
  always_ff @(posedge mclk) begin
    if (!rst_n || !attached_q || !scan_q) begin
      tap_q <= edp_pkg::EDP_TLR;
    end else if (tck_r) begin
      tap_q <= tap_d;
    end
  end
  assign tap_reset = (tap_q == edp_pkg::EDP_TLR);

  // instruction shift and parallel capture into both registers
  logic [3:0] ir_sh_q;
  logic [3:0] ir_bs_q;
  logic [3:0] ir_dp_q;
  always_ff @(posedge mclk) begin
    if (!rst_n || tap_q == edp_pkg::EDP_TLR) begin
      ir_sh_q <= 4'h0;
      ir_bs_q <= edp_pkg::IR_RESET;
      ir_dp_q <= edp_pkg::IR_RESET;
    end else if (tck_r) begin
      if (tap_q == edp_pkg::EDP_CAP_IR) begin
        ir_sh_q <= 4'h1;
      end else if (tap_q == edp_pkg::EDP_SH_IR) begin
        ir_sh_q <= {tdi_s_q[1], ir_sh_q[3:1]};
      end else if (tap_q == edp_pkg::EDP_UPD_IR) begin
        ir_bs_q <= ir_sh_q;
        ir_dp_q <= ir_sh_q;
      end
    end
  end
  assign ir_bscan = ir_bs_q;
  assign ir_dp = ir_dp_q;

  // single bit bypass register
  logic byp_q;
  always_ff @(posedge mclk) begin
    if (!rst_n || tap_q == edp_pkg::EDP_TLR) begin
      byp_q <= 1'b0;
    end else if (tck_r && tap_q == edp_pkg::EDP_SH_DR) begin
      byp_q <= tdi_s_q[1];
    end
  end
  assign shift_tdi = tdi_s_q[1];

  edp_ir_decode u_dec (
    .ir_bscan(ir_bs_q),
    .ir_dp(ir_dp_q),
    .scan_mode(scan_q),
    .dec(dec)
  );

  // mode select: run of highs, 16-bit code msb first, run of highs
  edp_pkg::edp_sel_type sel_q;
  logic [7:0] hcnt_q;
  logic [15:0] code_q;
  logic [4:0] nbit_q;
  logic to_sw_q;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      hcnt_q <= 8'h00;
    end else if (tck_r) begin
      if (!tms) begin
        hcnt_q <= 8'h00;
      end else if (hcnt_q != edp_pkg::HIGH_CNT_MAX) begin
        hcnt_q <= hcnt_q + 8'h01;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n || !pin_rst_n) begin
      sel_q <= edp_pkg::EDP_SW_IDLE;
      scan_q <= 1'b1;
      code_q <= 16'h0000;
      nbit_q <= 5'h00;
      to_sw_q <= 1'b0;
    end else if (tck_r) begin
      unique case (sel_q)
        edp_pkg::EDP_SW_IDLE: begin
          if (!tms && hcnt_q > 8'(edp_pkg::HIGH_MIN)) begin
            sel_q <= edp_pkg::EDP_SW_CODE;
            code_q <= 16'h0000;
            nbit_q <= 5'h01;
          end
        end
        edp_pkg::EDP_SW_CODE: begin
          if (nbit_q == 5'h10) begin
            if (code_q == edp_pkg::SEQ_TO_SW && scan_q) begin
              sel_q <= edp_pkg::EDP_SW_TAIL;
              to_sw_q <= 1'b1;
            end else if (code_q == edp_pkg::SEQ_TO_JTAG && !scan_q) begin
              sel_q <= edp_pkg::EDP_SW_TAIL;
              to_sw_q <= 1'b0;
            end else begin
              sel_q <= edp_pkg::EDP_SW_IDLE;
            end
          end else begin
            nbit_q <= nbit_q + 5'h01;
          end
        end
        edp_pkg::EDP_SW_TAIL: begin
          if (!tms) begin
            sel_q <= edp_pkg::EDP_SW_IDLE;
          end else if (hcnt_q > 8'(edp_pkg::HIGH_MIN)) begin
            sel_q <= edp_pkg::EDP_SW_IDLE;
            scan_q <= ~to_sw_q;
          end
        end
      endcase
      if (sel_q == edp_pkg::EDP_SW_CODE && nbit_q != 5'h10) begin
        code_q <= {code_q[14:0], tms};
      end
    end
  end
  assign scan_mode = scan_q;

  // first zero bit counted into the code while idle
  // data-out steering and pin ownership
  always_comb begin
    tdo_out = 1'b0;
    tdo_oe_n = 1'b1;
    if (attached_q && scan_q) begin
      tdo_oe_n = 1'b0;
      if (dec.bscan_hit) begin
        tdo_out = dec.clamp ? byp_q : bsr_tdo;
      end else if (dec.bypass) begin
        tdo_out = byp_q;
      end else begin
        tdo_out = dp_tdo;
      end
    end else if (attached_q && trace_en) begin
      tdo_oe_n = 1'b0;
      tdo_out = trace_serial_output;
    end
  end

  // serial-wire data line drive
  assign mode_data_line_out = swd_out;
  assign mode_data_line_oe_n = ~(attached_q && !scan_q && swd_drive);
  assign tdi_tdo_released = ~scan_q;

  // access port select
  assign sel_system_bus_ap = (access_port_select == edp_pkg::ACCESS_PORT_SELECT_BUS);
  assign sel_system_manager_ap =
    (access_port_select == edp_pkg::ACCESS_PORT_SELECT_SYSTEM_MANAGER_ACCESS_PORT);
endmodule

// [design/edp_pkg.sv]
// How it works
// - after reset release, first probe clock fall means a debugger attached
// - on attach, debug pins are forced to debug function, no device reset
// - attach never halts or resets the running core
// - probe clock held low through reset release raises a core reset request
// - system manager port may withdraw that core reset request
// - after reset the combined port runs in scan-chain mode
// - over 50 highs, 0x79e7 msb first, over 50 highs selects serial-wire
// - over 50 highs, 0x3ce7 msb first, over 50 highs returns to scan-chain
// - trace output uses data-out pin only in serial-wire mode
// - boundary-scan controller and instructions unavailable in serial-wire mode
// - both controllers capture each shifted instruction into their own register
// - data-out comes from boundary-scan when it knows the instruction
// - access port select 0 is system bus, 1 is system manager
// - 0000 extest, 0001 sample/preload, 0100 intest use boundary chain
// - 0101 clamp uses bypass bit while pins driven from boundary register
// - 1000 abort, 1010 dp access, 1011 ap access, 1110 idcode, 1100/1101 reserved
// - 1111 selects the one-bit bypass register
// - port enables only on a clock fall seen while reset pin is released
// - instruction and bypass registers held reset while tap sits in test-logic-reset
// - serial-wire mode releases data-in and data-out pins to alternates
// - instruction and data patterns shift least significant bit first
package edp_pkg;
  localparam int unsigned IR_W = 4;
  localparam logic [3:0] IR_EXTEST = 4'h0;
  localparam logic [3:0] IR_SAMPLE = 4'h1;
  localparam logic [3:0] IR_INTEST = 4'h4;
  localparam logic [3:0] IR_CLAMP = 4'h5;
  localparam logic [3:0] IR_ABORT = 4'h8;
  localparam logic [3:0] IR_DEBUG_PORT_ACCESS = 4'ha;
  localparam logic [3:0] IR_ACCESS_PORT_ACCESS = 4'hb;
  localparam logic [3:0] IR_RSVD0 = 4'hc;
  localparam logic [3:0] IR_RSVD1 = 4'hd;
  localparam logic [3:0] IR_IDCODE = 4'he;
  localparam logic [3:0] IR_BYPASS = 4'hf;
  localparam logic [3:0] IR_RESET = 4'he; // idcode after tap reset
  localparam logic [15:0] SEQ_TO_SW = 16'h79e7;
  localparam logic [15:0] SEQ_TO_JTAG = 16'h3ce7;
  localparam int unsigned HIGH_MIN = 50; // strictly more than this
  localparam logic [7:0] HIGH_CNT_MAX = 8'hff;
  localparam logic ACCESS_PORT_SELECT_BUS = 1'b0;
  localparam logic ACCESS_PORT_SELECT_SYSTEM_MANAGER_ACCESS_PORT = 1'b1;

  typedef enum logic [3:0] {
    EDP_TLR, EDP_RTI, EDP_SEL_DR, EDP_CAP_DR, EDP_SH_DR, EDP_EX1_DR,
    EDP_PA_DR, EDP_EX2_DR, EDP_UPD_DR, EDP_SEL_IR, EDP_CAP_IR, EDP_SH_IR,
    EDP_EX1_IR, EDP_PA_IR, EDP_EX2_IR, EDP_UPD_IR
  } edp_tap_type;

  typedef enum logic [1:0] {
    EDP_SW_IDLE, EDP_SW_CODE, EDP_SW_TAIL
  } edp_sel_type;

  // decoded instruction outputs toward on-chip debug logic
  typedef struct packed {
    logic bscan_hit;
    logic use_bsr;
    logic clamp;
    logic extest;
    logic intest;
    logic abort;
    logic debug_port_access;
    logic access_port_access;
    logic idcode;
    logic bypass;
  } edp_dec_type;
endpackage

// [design/edp_ir_decode.sv]
`timescale 1ns/1ns
module edp_ir_decode (
  input wire logic [3:0] ir_bscan,
  input wire logic [3:0] ir_dp,
  input wire logic scan_mode,
  output edp_pkg::edp_dec_type dec
);
  // both instruction registers decoded side by side
  always_comb begin
    dec = '0;
    if (scan_mode) begin
      unique case (ir_bscan)
        edp_pkg::IR_EXTEST: begin
          dec.bscan_hit = 1'b1;
          dec.use_bsr = 1'b1;
          dec.extest = 1'b1;
        end
        edp_pkg::IR_SAMPLE: begin
          dec.bscan_hit = 1'b1;
          dec.use_bsr = 1'b1;
        end
        edp_pkg::IR_INTEST: begin
          dec.bscan_hit = 1'b1;
          dec.use_bsr = 1'b1;
          dec.intest = 1'b1;
        end
        edp_pkg::IR_CLAMP: begin
          dec.bscan_hit = 1'b1;
          dec.clamp = 1'b1;
        end
        default: dec.bscan_hit = 1'b0;
      endcase
      unique case (ir_dp)
        edp_pkg::IR_ABORT: dec.abort = 1'b1;
        edp_pkg::IR_DEBUG_PORT_ACCESS: dec.debug_port_access = 1'b1;
        edp_pkg::IR_ACCESS_PORT_ACCESS: dec.access_port_access = 1'b1;
        edp_pkg::IR_IDCODE: dec.idcode = 1'b1;
        edp_pkg::IR_RSVD0, edp_pkg::IR_RSVD1: dec.bypass = 1'b1;
        edp_pkg::IR_BYPASS: dec.bypass = 1'b1;
        default: dec.bypass = 1'b1;
      endcase
    end
  end
endmodule

// [tb/edp_probe_model.sv]
`timescale 1ns/1ns
module edp_probe_model (
  input wire logic mclk,
  output logic tck,
  output logic tms,
  output logic tdi
);
  // probe clock idles high between frames
  initial begin
    tck = 1'b1;
    tms = 1'b1;
    tdi = 1'b0;
  end
  // one 160 ns probe clock period, lines set on the falling half
  task automatic pulse(input logic m, input logic d);
    @(posedge mclk);
    tms <= m;
    tdi <= d;
    tck <= 1'b0;
    repeat (4) @(posedge mclk);
    tck <= 1'b1;
    repeat (3) @(posedge mclk);
  endtask
  // highs, code msb first, highs
  task automatic mode_seq(input logic [15:0] code);
    repeat (52) pulse(1'b1, 1'b0);
    for (int i = 15; i >= 0; i--) pulse(code[i], 1'b0);
    repeat (52) pulse(1'b1, 1'b0);
  endtask
  // clock held at a level across external reset release
  task automatic hold(input logic v);
    @(posedge mclk);
    tck <= v;
  endtask
endmodule

// [tb/edp_top_sva.sv]
`timescale 1ns/1ns
module edp_top_sva (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic dp_tdo,
  input wire logic bsr_tdo,
  input wire logic trace_serial_output,
  input wire logic trace_en,
  input wire logic system_manager_access_port_release,
  input wire logic access_port_select,
  input wire logic tdo_out,
  input wire logic tdo_oe_n,
  input wire logic debugger_attached,
  input wire logic pins_forced,
  input wire logic tdi_tdo_released,
  input wire logic core_reset_req,
  input wire logic scan_mode,
  input wire logic tap_reset,
  input wire logic tck_fall,
  input wire logic [3:0] ir_bscan,
  input wire logic [3:0] ir_dp,
  input wire edp_pkg::edp_dec_type dec,
  input wire logic sel_system_bus_ap,
  input wire logic sel_system_manager_ap
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // output checks
  AST_TDO_SRC: assert property (scan_mode && !tdo_oe_n && !dec.clamp
    && (dec.bscan_hit || !dec.bypass) |->
    tdo_out == (dec.bscan_hit ? bsr_tdo : dp_tdo)) else $error("tdo src");
  AST_TRACE: assert property (!scan_mode && trace_en && !tdo_oe_n |->
    tdo_out == trace_serial_output) else $error("trace path");
  AST_SW_NO_BSCAN: assert property (!scan_mode |-> !dec.bscan_hit)
    else $error("bscan in serial mode");
  AST_ACCESS_PORT_SELECT: assert property (sel_system_manager_ap == access_port_select
    && sel_system_bus_ap == !access_port_select) else $error("access_port_select");
  AST_RELEASE: assert property (tdi_tdo_released == !scan_mode)
    else $error("pin release");
  AST_ATTACH_FALL: assert property ($rose(debugger_attached) |->
    $past(tck_fall)) else $error("attach without fall");
  AST_FORCED: assert property (debugger_attached |-> pins_forced)
    else $error("pins not forced");
  AST_TLR_IR: assert property (tap_reset && $past(tap_reset) |->
    ir_dp == 4'he && ir_bscan == 4'he) else $error("ir not reset");
  AST_IR_PAR: assert property (scan_mode && !tap_reset |->
    ir_bscan == ir_dp) else $error("ir differ");
  AST_BSC_DEC: assert property (scan_mode && ir_bscan inside
    {4'h0, 4'h1, 4'h4} |-> dec.bscan_hit && dec.use_bsr) else $error("dec");
  AST_CRR_HOLD: assert property (core_reset_req && !system_manager_access_port_release
    |=> core_reset_req) else $error("core reset dropped");
  AST_CRR_DROP: assert property (core_reset_req && system_manager_access_port_release
    |-> ##[0:3] !core_reset_req) else $error("core reset kept");
  COV_ATTACH: cover property ($rose(debugger_attached));
  COV_SW: cover property ($fell(scan_mode));
  COV_CRR: cover property ($rose(core_reset_req));
endmodule

bind edp_top edp_top_sva u_edp_top_sva (.mclk(mclk), .rst_n(rst_n),
  .dp_tdo(dp_tdo), .bsr_tdo(bsr_tdo), .trace_en(trace_en),
  .trace_serial_output(trace_serial_output), .system_manager_access_port_release(system_manager_access_port_release),
  .access_port_select(access_port_select), .tdo_out(tdo_out),
  .tdo_oe_n(tdo_oe_n), .debugger_attached(debugger_attached),
  .pins_forced(pins_forced), .tdi_tdo_released(tdi_tdo_released),
  .core_reset_req(core_reset_req), .scan_mode(scan_mode),
  .tap_reset(tap_reset), .tck_fall(tck_fall), .ir_bscan(ir_bscan),
  .ir_dp(ir_dp), .dec(dec), .sel_system_bus_ap(sel_system_bus_ap),
  .sel_system_manager_ap(sel_system_manager_ap));

// [tb/tb_edp_top.sv]
`timescale 1ns/1ns
module tb_edp_top;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic reset_pin_n = 1'b1;
  logic trace_serial_output = 1'b0;
  logic trace_en = 1'b0;
  logic dp_tdo = 1'b0;
  logic bsr_tdo = 1'b1;
  logic system_manager_access_port_release = 1'b0;
  logic access_port_select = 1'b0;
  logic swd_out = 1'b0;
  logic swd_drive = 1'b0;
  logic mdl_out, mdl_oe_n, tap_reset;
  logic tck, tms, tdi, tdo_out, tdo_oe_n, debugger_attached, pins_forced;
  logic tdi_tdo_released, core_reset_req, scan_mode, sel_bus, sel_system_manager_access_port;
  logic [3:0] ir_bscan, ir_dp;
  edp_pkg::edp_dec_type dec;
  int fail_count = 0;
  int num_checks = 0;
  int cyc = 0;
  `define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin \
    fail_count++; $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); \
    end end
  always #10 mclk = ~mclk;
  edp_probe_model u_edp_probe_model (.mclk(mclk), .tck(tck), .tms(tms),
    .tdi(tdi));
  edp_top u_edp_top (.mclk(mclk), .rst_n(rst_n), .probe_clock_line(tck),
    .reset_pin_n(reset_pin_n), .mode_data_line_in(tms),
    .mode_data_line_out(mdl_out), .mode_data_line_oe_n(mdl_oe_n),
    .tdi_in(tdi),
    .tdo_out(tdo_out), .tdo_oe_n(tdo_oe_n),
    .trace_serial_output(trace_serial_output), .trace_en(trace_en),
    .swd_out(swd_out), .swd_drive(swd_drive), .dp_tdo(dp_tdo),
    .bsr_tdo(bsr_tdo),
    .system_manager_access_port_release(system_manager_access_port_release), .access_port_select(access_port_select),
    .debugger_attached(debugger_attached), .pins_forced(pins_forced),
    .tdi_tdo_released(tdi_tdo_released), .core_reset_req(core_reset_req),
    .scan_mode(scan_mode), .tap_reset(tap_reset), .ir_bscan(ir_bscan),
    .ir_dp(ir_dp),
    .dec(dec), .sel_system_bus_ap(sel_bus), .sel_system_manager_ap(sel_system_manager_access_port),
    .tck_rise(), .tck_fall(), .shift_tdi());
  task automatic report_and_stop;
    $display("checks=%0d mismatches=%0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic t_attach;
    `CHK(scan_mode, 1'b1)
    `CHK(debugger_attached, 1'b0)
    u_edp_probe_model.pulse(1'b1, 1'b0);
    #1;
    `CHK(debugger_attached, 1'b1)
    `CHK(pins_forced, 1'b1)
    `CHK(tdo_oe_n, 1'b0)
    `CHK(core_reset_req, 1'b0)
    $display("test attach done");
  endtask
  // walk tap from reset into shift-ir, shift lsb first, update, idle
  task automatic t_ir;
    logic [3:0] c;
    logic [6:0] ex;
    logic hit;
    logic tx;
    for (int k = 0; k < 16; k++) begin
      c = 4'(k);
      dp_tdo <= k[0];
      bsr_tdo <= ~k[0];
      for (int i = 0; i < 10; i++) u_edp_probe_model.pulse(10'h0df >> i, 1'b0);
      for (int i = 0; i < 4; i++) u_edp_probe_model.pulse(i == 3, c[i]);
      u_edp_probe_model.pulse(1'b1, 1'b0);
      u_edp_probe_model.pulse(1'b0, 1'b0);
      #1;
      hit = (c == 4'h0) || (c == 4'h1) || (c == 4'h4) || (c == 4'h5);
      // boundary chain, debug port source, or bypass bit (still zero)
      if (hit && c != 4'h5)
        tx = ~c[0];
      else if (c == 4'h8 || c == 4'ha || c == 4'hb || c == 4'he)
        tx = c[0];
      else
        tx = 1'b0;
      ex = {c == 4'h0, c == 4'h4, c == 4'h5, c == 4'h8, c == 4'ha,
        c == 4'hb, c == 4'he};
      `CHK(ir_dp, c)
      `CHK(ir_bscan, c)
      `CHK(tdo_out, tx)
      `CHK(tap_reset, 1'b0)
      `CHK(dec.bscan_hit, hit)
      `CHK({dec.extest, dec.intest, dec.clamp, dec.abort, dec.debug_port_access,
        dec.access_port_access, dec.idcode}, ex)
      if (c == 4'hf) `CHK(dec.bypass, 1'b1)
    end
    $display("test ir done");
  endtask
  task automatic t_switch;
    trace_en <= 1'b1;
    trace_serial_output <= 1'b1;
    u_edp_probe_model.mode_seq(16'h79e7);
    #1;
    `CHK(scan_mode, 1'b0)
    `CHK(tdi_tdo_released, 1'b1)
    `CHK(dec.bscan_hit, 1'b0)
    `CHK(tdo_out, 1'b1)
    `CHK(tap_reset, 1'b1)
    swd_drive <= 1'b1;
    swd_out <= 1'b1;
    @(posedge mclk);
    #1;
    `CHK(mdl_oe_n, 1'b0)
    `CHK(mdl_out, 1'b1)
    trace_serial_output <= 1'b0;
    u_edp_probe_model.mode_seq(16'h79e7);
    #1;
    `CHK(scan_mode, 1'b0)
    `CHK(tdo_out, 1'b0)
    u_edp_probe_model.mode_seq(16'h3ce7);
    #1;
    `CHK(scan_mode, 1'b1)
    `CHK(mdl_oe_n, 1'b1)
    trace_en <= 1'b0;
    swd_drive <= 1'b0;
    $display("test switch done");
  endtask
  task automatic t_core;
    reset_pin_n <= 1'b0;
    u_edp_probe_model.hold(1'b0);
    repeat (8) @(posedge mclk);
    #1;
    `CHK(debugger_attached, 1'b0)
    reset_pin_n <= 1'b1;
    repeat (8) @(posedge mclk);
    #1;
    `CHK(core_reset_req, 1'b1)
    system_manager_access_port_release <= 1'b1;
    repeat (8) @(posedge mclk);
    #1;
    `CHK(core_reset_req, 1'b0)
    system_manager_access_port_release <= 1'b0;
    u_edp_probe_model.hold(1'b1);
    for (int v = 0; v < 2; v++) begin
      access_port_select <= 1'(v);
      @(posedge mclk);
      #1;
      `CHK(sel_system_manager_access_port, 1'(v))
      `CHK(sel_bus, !1'(v))
    end
    $display("test core reset done");
  endtask
  // hang guard
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      report_and_stop;
    end
  end
  initial begin
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    #1;
    t_attach;
    t_ir;
    t_switch;
    t_core;
    report_and_stop;
  end
endmodule
